// ===== logic/dncap_serout.sv
// link-side serial capture output, clocked by the bit clock.
// assumes the frame clock changes away from the rising bit clock edge.
module dncap_serout
  import dncap_pkg::*;
(
  // link clocks
  input  wire logic         bclk,
  input  wire logic         lrclk,
  // hand-off from the core domain
  input  wire logic         srst,
  input  wire logic         req_tgl,
  input  wire dncap_xfer_s  xfer,
  output logic              ack_tgl,
  // serial capture pin
  output logic              capture_serial_out_pin
);

  logic [1:0]       sq;
  logic             lrst;
  logic             req_s;
  logic             ack_ff;
  dncap_xfer_s      words_ff;
  logic             lr_prev_ff;
  logic [CAP_W-1:0] sh_ff;
  logic             dout_ff;
  logic             frame_edge;
  logic [CAP_W-1:0] slot_word;

  // reset and request both cross into the link domain
  dncap_sync #(.W(2)) u_sync (
    .clk  (bclk),
    .din  ({req_tgl, srst}),
    .dout (sq)
  );

  assign lrst    = sq[0];
  assign req_s   = sq[1];
  assign ack_tgl = ack_ff;
  assign capture_serial_out_pin = dout_ff;

  // [RQ16] left slot while frame clock high
  assign frame_edge = lrclk != lr_prev_ff;
  assign slot_word  = lrclk ? words_ff.left : words_ff.right;

  // toggle handshake: xfer is held stable until ack returns
  always_ff @(posedge bclk) begin
    if (lrst) begin
      ack_ff   <= 1'b0;
      words_ff <= '0;
    end else if (req_s != ack_ff) begin
      words_ff <= xfer;
      ack_ff   <= req_s;
    end
  end

  // [RQ6] frame clock framing
  // [RQ19] msb first shifting
  always_ff @(posedge bclk) begin
    if (lrst) begin
      lr_prev_ff <= 1'b0;
      sh_ff      <= '0;
      dout_ff    <= 1'b0;
    end else begin
      lr_prev_ff <= lrclk;
      if (frame_edge) begin
        dout_ff <= slot_word[CAP_W-1];
        sh_ff   <= {slot_word[CAP_W-2:0], 1'b0};
      end else begin
        dout_ff <= sh_ff[CAP_W-1];
        sh_ff   <= {sh_ff[CAP_W-2:0], 1'b0};
      end
    end
  end

endmodule

// ===== logic/dncap_sync.sv
// multi-bit level synchroniser, three stages plus an agreement stage.
// assumes each bit is an independent level; no word coherence given.
module dncap_sync #(
  parameter int W = 1
)(
  // destination clock
  input  wire logic         clk,
  // asynchronous levels in, settled levels out
  input  wire logic [W-1:0] din,
  output logic [W-1:0]      dout
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] out_ff;
  logic [W-1:0] nxt_out;

  // a bit moves only once stages two and three agree
  assign nxt_out = (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & out_ff);
  assign dout    = out_ff;

  // no reset: data path only, settles within four edges
  always_ff @(posedge clk) begin
    s1_ff  <= din;
    s2_ff  <= s1_ff;
    s3_ff  <= s2_ff;
    out_ff <= nxt_out;
  end

endmodule

// ===== logic/dncap_top.sv
// node data capture: spi slave, halt sequencing, source selectors,
// four capture units and the hand-off to the serial capture link.
// assumes spi and link pins are asynchronous to clock, and the core
// presents its step index and tap values on clock with a valid strobe.

// Overview of operation
// [RQ1] data and master clock source fields come from control register two
// [RQ2] writing halt ramps volume down, then stops the core
// [RQ3] bit one of control register one reads back completed shutdown
// [RQ4] host changes sources only after shutdown, restarts by clearing halt
// [RQ5] four capture units: two readable by host, two feed serial pin
// [RQ6] serial pin framed by the same frame and bit clocks as input
// [RQ7] each unit holds a step index from 0 to 511
// [RQ8] on step match, selected core register is copied into the unit
// [RQ9] select 00 mult out, 01 log level, 10 data in, 11 coef in
// [RQ10] setup registers answer at addresses 261 to 264
// [RQ11] mult out capture is 1.23, clipped above full scale
// [RQ12] log level capture is 5.19, level is -87 plus three times value
// [RQ13] multiplier data input capture is 3.21 format
// [RQ14] setup word is step index above the two select bits
// [RQ15] reads of 261 and 262 return host units one and two
// [RQ16] serial unit one in left slot, unit two in right slot
// [RQ17] data bytes: step bits 8..6, then step 5..0 with select
// [RQ18] capture read returns zero byte then 24 bits msb first
// [RQ19] serial output is twos complement, msb first, left before right
// [RQ20] captured value held until the next matching step
module dncap_top
  import dncap_pkg::*;
#(
  parameter int RAMP_CYCLES_P = RAMP_CYCLES,
  localparam int RAMP_W = $clog2(RAMP_CYCLES_P + 1)
)(
  // core clock and reset
  input  wire logic              clock,
  input  wire logic              srst,
  // spi control port
  input  wire logic              spi_sclk,
  input  wire logic              spi_cs_n,
  input  wire logic              spi_mosi,
  output logic                   spi_miso,
  output logic                   spi_miso_oe_n,
  // dsp core taps
  input  wire logic              core_step_valid,
  input  wire logic [STEP_W-1:0] core_pc,
  input  wire dncap_taps_s       core_taps,
  // core control
  output logic                   core_run,
  output logic [RAMP_W-1:0]      volume_level,
  output logic [SRC_W-1:0]       data_src_sel,
  output logic [SRC_W-1:0]       mclk_src_sel,
  // serial capture link
  input  wire logic              bclk,
  input  wire logic              lrclk,
  output logic                   capture_serial_out_pin
);

  localparam logic [RAMP_W-1:0] RAMP_MAX = RAMP_W'(RAMP_CYCLES_P);
  localparam logic [RAMP_W-1:0] RAMP_ONE = RAMP_W'(1);

  // [RQ11] saturate guard bits into 1.23
  function automatic logic [CAP_W-1:0] clip_mult(
    input logic [MULT_W-1:0] v
  );
    logic [MULT_W-CAP_W:0] top;
    top = v[MULT_W-1:CAP_W-1];
    if (&top || ~|top)
      clip_mult = v[CAP_W-1:0];
    else
      clip_mult = v[MULT_W-1] ? CAP_MIN : CAP_MAX;
  endfunction

  // [RQ9] node register select decode
  // [RQ12] log level passes as 5.19
  // [RQ13] data input passes as 3.21
  function automatic logic [CAP_W-1:0] tap_sel(
    input logic [SEL_W-1:0] sel,
    input dncap_taps_s      t
  );
    unique case (sel)
      SEL_MULT_OUT:  tap_sel = clip_mult(t.mult_out);
      SEL_LOG_LEVEL: tap_sel = t.log_level_output;
      SEL_MULT_DATA: tap_sel = t.multiplier_data_in;
      SEL_MULT_COEF: tap_sel = t.multiplier_coef_in;
    endcase
  endfunction

  function automatic logic is_cap(input logic [ADDR_W-1:0] a);
    is_cap = (a >= ADDR_HOST_CAP1) && (a <= ADDR_SER_CAP2);
  endfunction

  function automatic logic [1:0] cap_idx(input logic [ADDR_W-1:0] a);
    cap_idx = 2'(a - ADDR_HOST_CAP1);
  endfunction

  // synchronised pins and returning ack
  logic [3:0]          sync_q;
  logic                sclk_s;
  logic                cs_act;
  logic                mosi_s;
  logic                ack_s;
  logic                ack_tgl;

  // spi framing state
  logic                  sclk_prev_ff;
  logic [BYTE_CNT_W-1:0] bit_cnt_ff;
  logic [BYTE_CNT_W-1:0] byte_cnt_ff;
  logic [BYTE_W-1:0]     shift_in_ff;
  logic                  rw_ff;
  logic [ADDR_W-1:0]     addr_ff;
  logic [BYTE_W-1:0]     data_hi_ff;
  logic [RD_W-1:0]       rd_sh_ff;
  logic                  miso_ff;
  logic                  miso_oe_n_ff;
  logic                  sclk_rise;
  logic                  sclk_fall;
  logic                  byte_done;
  logic [BYTE_W-1:0]     rx_byte;
  logic                  wr_commit;
  logic                  rd_load;
  logic [ADDR_W-1:0]     rd_addr;
  logic [WR_W-1:0]       wr_data;
  dncap_setup_s          wr_setup;
  logic [SRC_W-1:0]      wr_data_src;
  logic [SRC_W-1:0]      wr_mclk_src;
  logic [RD_W-1:0]       rd_word;
  logic [BYTE_W-1:0]     ctrl1_stat;

  // control and capture state
  logic                  halt_ff;
  logic [SRC_W-1:0]      data_src_ff;
  logic [SRC_W-1:0]      mclk_src_ff;
  dncap_setup_s          setup_ff [NUM_UNITS];
  logic [CAP_W-1:0]      cap_ff [NUM_UNITS];
  logic [NUM_UNITS-1:0]  hit;
  logic [CAP_W-1:0]      tap_val [NUM_UNITS];
  dncap_core_e           state_ff;
  dncap_core_e           nxt_state;
  logic [RAMP_W-1:0]     ramp_ff;
  logic [RAMP_W-1:0]     nxt_ramp;
  logic                  core_run_ff;
  logic                  req_ff;
  dncap_xfer_s           xfer_ff;
  logic                  xfer_idle;

  // one synchroniser bank for the spi pins and the returning ack
  dncap_sync #(.W(4)) u_sync (
    .clk  (clock),
    .din  ({ack_tgl, spi_mosi, spi_cs_n, spi_sclk}),
    .dout (sync_q)
  );

  assign sclk_s = sync_q[0];
  assign cs_act = ~sync_q[1];
  assign mosi_s = sync_q[2];
  assign ack_s  = sync_q[3];

  // spi edge and byte decode
  assign sclk_rise = cs_act & sclk_s & ~sclk_prev_ff;
  assign sclk_fall = cs_act & ~sclk_s & sclk_prev_ff;
  assign byte_done = bit_cnt_ff == BIT_LAST;
  assign rx_byte   = {shift_in_ff[BYTE_W-2:0], mosi_s};
  assign rd_addr   = {addr_ff[ADDR_W-1:BYTE_W], rx_byte};
  assign wr_commit = sclk_rise & byte_done & (byte_cnt_ff == BYTE_D1) & ~rw_ff;
  assign rd_load   = sclk_rise & byte_done & (byte_cnt_ff == BYTE_ADDR) & rw_ff;

  // [RQ14] setup word taken whole from the two data bytes
  // [RQ17] step 8..6 low in first byte, step 5..0 and select next
  assign wr_data     = {data_hi_ff, rx_byte};
  assign wr_setup    = wr_data[SETUP_W-1:0];
  assign wr_data_src = wr_data[CTRL2_DATA_LSB +: SRC_W];
  assign wr_mclk_src = wr_data[CTRL2_MCLK_LSB +: SRC_W];

  // [RQ3] shutdown done and ramp status for control one reads
  assign ctrl1_stat = (BYTE_W'(state_ff == CORE_HALTED) << CTRL1_DONE_BIT)
                    | (BYTE_W'(state_ff == CORE_RAMP) << CTRL1_RAMP_BIT);

  // [RQ15] host units read back; unmapped reads give zeros
  // [RQ18] zero byte then capture msb first
  assign rd_word = (rd_addr == ADDR_HOST_CAP1 || rd_addr == ADDR_HOST_CAP2)
                 ? {ZERO_BYTE, cap_ff[cap_idx(rd_addr)]}
                 : (rd_addr == ADDR_CTRL1)
                 ? {ctrl1_stat, {(RD_W-BYTE_W){1'b0}}}
                 : '0;

  // bit and byte counters restart with every chip select
  always_ff @(posedge clock) begin
    sclk_prev_ff <= srst ? 1'b0 : sclk_s;
    if (srst || !cs_act) begin
      bit_cnt_ff  <= '0;
      byte_cnt_ff <= '0;
      shift_in_ff <= '0;
    end else if (sclk_rise) begin
      shift_in_ff <= rx_byte;
      bit_cnt_ff  <= bit_cnt_ff + 3'h1;
      if (byte_done && byte_cnt_ff != BYTE_SAT)
        byte_cnt_ff <= byte_cnt_ff + 3'h1;
    end
  end

  // header, address and first data byte
  always_ff @(posedge clock) begin
    if (srst) begin
      rw_ff      <= 1'b0;
      addr_ff    <= '0;
      data_hi_ff <= '0;
    end else if (sclk_rise && byte_done) begin
      if (byte_cnt_ff == BYTE_HDR) begin
        rw_ff <= rx_byte[HDR_RW_BIT];
        addr_ff[ADDR_W-1:BYTE_W] <= rx_byte[ADDR_W-BYTE_W-1:0];
      end
      if (byte_cnt_ff == BYTE_ADDR)
        addr_ff[BYTE_W-1:0] <= rx_byte;
      if (byte_cnt_ff == BYTE_D0)
        data_hi_ff <= rx_byte;
    end
  end

  // read shifter; snapshot at load keeps a multi-byte read coherent
  always_ff @(posedge clock) begin
    if (srst) begin
      rd_sh_ff     <= '0;
      miso_ff      <= 1'b0;
      miso_oe_n_ff <= 1'b1;
    end else begin
      miso_oe_n_ff <= ~cs_act;
      if (rd_load) begin
        rd_sh_ff <= rd_word;
      end else if (sclk_fall) begin
        miso_ff  <= rd_sh_ff[RD_W-1];
        rd_sh_ff <= {rd_sh_ff[RD_W-2:0], 1'b0};
      end
    end
  end

  // [RQ10] setup registers at 261..264
  // [RQ1] source selectors from control two
  always_ff @(posedge clock) begin
    if (srst) begin
      halt_ff     <= 1'b0;
      data_src_ff <= '0;
      mclk_src_ff <= '0;
      for (int i = 0; i < NUM_UNITS; i++)
        setup_ff[i] <= '0;
    end else if (wr_commit) begin
      if (is_cap(addr_ff))
        setup_ff[cap_idx(addr_ff)] <= wr_setup;
      if (addr_ff == ADDR_CTRL1)
        halt_ff <= wr_data[CTRL1_HALT_BIT];
      if (addr_ff == ADDR_CTRL2) begin
        data_src_ff <= wr_data_src;
        mclk_src_ff <= wr_mclk_src;
      end
    end
  end

  // [RQ5] four independent units
  // [RQ7] nine-bit step compare
  // [RQ8] step match selects the tap
  for (genvar g = 0; g < NUM_UNITS; g++) begin : g_unit
    assign hit[g] = core_step_valid
                  && (core_pc == setup_ff[g].capture_step_index);
    assign tap_val[g] = tap_sel(setup_ff[g].node_register_select, core_taps);
  end

  // [RQ20] units hold until their next match
  always_ff @(posedge clock) begin
    for (int i = 0; i < NUM_UNITS; i++) begin
      if (srst)
        cap_ff[i] <= '0;
      else if (hit[i])
        cap_ff[i] <= tap_val[i];
    end
  end

  // [RQ2] ramp down then halt
  // [RQ4] clearing halt restarts and ramps back up
  always_comb begin
    nxt_state = state_ff;
    nxt_ramp  = ramp_ff;
    unique case (state_ff)
      CORE_RUN: begin
        if (ramp_ff != RAMP_MAX)
          nxt_ramp = ramp_ff + RAMP_ONE;
        if (halt_ff)
          nxt_state = CORE_RAMP;
      end
      CORE_RAMP: begin
        if (!halt_ff)
          nxt_state = CORE_RUN;
        else if (ramp_ff == '0)
          nxt_state = CORE_HALTED;
        else
          nxt_ramp = ramp_ff - RAMP_ONE;
      end
      CORE_HALTED: begin
        if (!halt_ff)
          nxt_state = CORE_RUN;
      end
    endcase
  end

  // core sequencer registers; volume starts at full scale
  always_ff @(posedge clock) begin
    if (srst) begin
      state_ff    <= CORE_RUN;
      ramp_ff     <= RAMP_MAX;
      core_run_ff <= 1'b1;
    end else begin
      state_ff    <= nxt_state;
      ramp_ff     <= nxt_ramp;
      core_run_ff <= nxt_state != CORE_HALTED;
    end
  end

  // toggle hand-off: the word stays frozen while a request is in flight
  assign xfer_idle = req_ff == ack_s;

  // [RQ16] unit one to left word, unit two to right word
  always_ff @(posedge clock) begin
    if (srst) begin
      req_ff  <= 1'b0;
      xfer_ff <= '0;
    end else if (xfer_idle) begin
      xfer_ff.left  <= cap_ff[UNIT_SER1];
      xfer_ff.right <= cap_ff[UNIT_SER2];
      req_ff        <= ~req_ff;
    end
  end

  // [RQ5] serial units drive the capture pin
  dncap_serout u_serout (
    .bclk                   (bclk),
    .lrclk                  (lrclk),
    .srst                   (srst),
    .req_tgl                (req_ff),
    .xfer                   (xfer_ff),
    .ack_tgl                (ack_tgl),
    .capture_serial_out_pin (capture_serial_out_pin)
  );

  // outputs straight from registers
  assign spi_miso      = miso_ff;
  assign spi_miso_oe_n = miso_oe_n_ff;
  assign core_run      = core_run_ff;
  assign volume_level  = ramp_ff;
  assign data_src_sel  = data_src_ff;
  assign mclk_src_sel  = mclk_src_ff;

  // checks on the core clock
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  AST_CAP_TAKE: assert property ( // [RQ8]
    hit[2] |=> cap_ff[2] == $past(tap_val[2]))
    else $error("capture unit missed its step match");
  AST_LOG_SEL: assert property ( // [RQ9]
    hit[1] && setup_ff[1].node_register_select == SEL_LOG_LEVEL
    |=> cap_ff[1] == $past(core_taps.log_level_output))
    else $error("log level select captured wrong tap");
  AST_CLIP: assert property ( // [RQ11]
    hit[0] && setup_ff[0].node_register_select == SEL_MULT_OUT
    && !core_taps.mult_out[MULT_W-1]
    && |core_taps.mult_out[MULT_W-2:CAP_W-1]
    |=> cap_ff[0] == CAP_MAX)
    else $error("positive overflow not clipped");
  AST_HOLD: assert property ( // [RQ20]
    !hit[0] |=> $stable(cap_ff[0]))
    else $error("capture changed without a match");
  AST_SETUP_WR: assert property ( // [RQ10]
    wr_commit && addr_ff == ADDR_HOST_CAP2
    |=> setup_ff[1] == $past(wr_setup))
    else $error("setup write not stored");
  AST_RD_FMT: assert property ( // [RQ18]
    rd_load && rd_addr == ADDR_HOST_CAP1
    |=> rd_sh_ff == {ZERO_BYTE, $past(cap_ff[0])})
    else $error("capture read word malformed");
  AST_HALT_DONE: assert property ( // [RQ2]
    state_ff == CORE_RAMP && ramp_ff == '0 && halt_ff
    |=> !core_run_ff && state_ff == CORE_HALTED)
    else $error("core not stopped after ramp");
  AST_RESTART: assert property ( // [RQ4]
    !halt_ff |=> state_ff != CORE_HALTED ##1 core_run_ff)
    else $error("core did not restart");
  AST_SRC: assert property ( // [RQ1]
    wr_commit && addr_ff == ADDR_CTRL2
    |=> data_src_sel == $past(wr_data_src)
        && mclk_src_sel == $past(wr_mclk_src))
    else $error("source selector not updated");
  AST_OE: assert property ( // [RQ18]
    !cs_act |=> spi_miso_oe_n)
    else $error("miso driven while deselected");

  COV_HALTED: cover property (state_ff == CORE_HALTED);
  COV_HOST_RD: cover property (rd_load && rd_addr == ADDR_HOST_CAP2);
  COV_SER_CAP: cover property (hit[UNIT_SER1]);
  COV_XFER: cover property (!xfer_idle ##1 xfer_idle);

endmodule

// ===== pkg/dncap_pkg.sv
// shared constants, types and layouts for the node data capture block.
// assumes a 25 MHz core clock and a 24-bit capture datapath.
package dncap_pkg;

  // clocking and halt timing
  localparam int CLK_HZ          = 25_000_000;
  localparam int HZ_PER_MHZ      = 1_000_000;
  localparam int SHUTDOWN_MAX_MS = 20;
  localparam int RAMP_TIME_US    = 10_000;
  localparam int RAMP_CYCLES     = RAMP_TIME_US * (CLK_HZ / HZ_PER_MHZ);

  // widths
  localparam int STEP_W      = 9;
  localparam int SEL_W       = 2;
  localparam int SETUP_W     = STEP_W + SEL_W;
  localparam int CAP_W       = 24;
  localparam int MULT_W      = 28;
  localparam int NUM_UNITS   = 4;
  localparam int ADDR_W      = 10;
  localparam int BYTE_W      = 8;
  localparam int RD_W        = 32;
  localparam int WR_W        = 16;
  localparam int SRC_W       = 2;
  localparam int BYTE_CNT_W  = 3;

  // register map
  localparam logic [ADDR_W-1:0] ADDR_CTRL1     = 10'h100;
  localparam logic [ADDR_W-1:0] ADDR_CTRL2     = 10'h101;
  localparam logic [ADDR_W-1:0] ADDR_HOST_CAP1 = 10'h105;
  localparam logic [ADDR_W-1:0] ADDR_HOST_CAP2 = 10'h106;
  localparam logic [ADDR_W-1:0] ADDR_SER_CAP1  = 10'h107;
  localparam logic [ADDR_W-1:0] ADDR_SER_CAP2  = 10'h108;

  // capture units that feed the serial pin
  localparam int UNIT_SER1 = 2;
  localparam int UNIT_SER2 = 3;

  // control register fields
  localparam int CTRL1_HALT_BIT  = 7;
  localparam int CTRL1_DONE_BIT  = 1;
  localparam int CTRL1_RAMP_BIT  = 0;
  localparam int CTRL2_DATA_LSB  = 4;
  localparam int CTRL2_MCLK_LSB  = 6;

  // spi frame layout
  localparam int HDR_RW_BIT = 2;
  localparam logic [BYTE_CNT_W-1:0] BYTE_HDR  = 3'h0;
  localparam logic [BYTE_CNT_W-1:0] BYTE_ADDR = 3'h1;
  localparam logic [BYTE_CNT_W-1:0] BYTE_D0   = 3'h2;
  localparam logic [BYTE_CNT_W-1:0] BYTE_D1   = 3'h3;
  localparam logic [BYTE_CNT_W-1:0] BYTE_SAT  = 3'h7;
  localparam logic [BYTE_CNT_W-1:0] BIT_LAST  = 3'h7;
  localparam logic [BYTE_W-1:0]     ZERO_BYTE = 8'h00;

  // node register select codes and saturation limits
  localparam logic [SEL_W-1:0] SEL_MULT_OUT  = 2'h0;
  localparam logic [SEL_W-1:0] SEL_LOG_LEVEL = 2'h1;
  localparam logic [SEL_W-1:0] SEL_MULT_DATA = 2'h2;
  localparam logic [SEL_W-1:0] SEL_MULT_COEF = 2'h3;
  localparam logic [CAP_W-1:0] CAP_MAX = 24'h7f_ffff;
  localparam logic [CAP_W-1:0] CAP_MIN = 24'h80_0000;

  // core taps: mult_out carries guard bits above the 1.23 range
  typedef struct packed {
    logic [MULT_W-1:0] mult_out;
    logic [CAP_W-1:0]  log_level_output;
    logic [CAP_W-1:0]  multiplier_data_in;
    logic [CAP_W-1:0]  multiplier_coef_in;
  } dncap_taps_s;

  // setup word: step index in the upper bits
  typedef struct packed {
    logic [STEP_W-1:0] capture_step_index;
    logic [SEL_W-1:0]  node_register_select;
  } dncap_setup_s;

  // words handed to the link domain
  typedef struct packed {
    logic [CAP_W-1:0] left;
    logic [CAP_W-1:0] right;
  } dncap_xfer_s;

  typedef enum logic [1:0] {CORE_RUN, CORE_RAMP, CORE_HALTED} dncap_core_e;

endpackage

// ===== verification/dncap_link_rx.sv
// serial capture receiver model: makes the link clocks, deframes the pin.
// assumes a free bit clock and 32 bit clocks per slot, left on lrclk high.
module dncap_link_rx (
  // pin from the device
  input  wire logic        capture_serial_out_pin,
  // link clocks driven here
  output logic             bclk,
  output logic             lrclk,
  // last words seen in each slot
  output logic [23:0]      left_word,
  output logic [23:0]      right_word
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0]  div_ff = 5'h00;
  logic [5:0]  cnt_ff = 6'h3f;
  logic        lr_q_ff = 1'b0;
  logic        slot_ff = 1'b0;
  logic [23:0] sh_ff;
  // bit clock runs free, phase unrelated to the core clock
  initial begin
    bclk = 1'b0;
    lrclk = 1'b0;
    #37;
    forever #80 bclk = ~bclk;
  end
  // frame clock moves on the falling edge, away from sampling
  always @(negedge bclk) begin
    div_ff <= div_ff + 5'h01;
    if (div_ff == 5'h1f) lrclk <= ~lrclk;
  end
  // msb sampled one bit clock after the frame edge, 24 bits kept
  always @(posedge bclk) begin
    lr_q_ff <= lrclk;
    if (lrclk != lr_q_ff) begin
      cnt_ff <= 6'h01;
      slot_ff <= lrclk;
    end else if (cnt_ff != 6'h3f) cnt_ff <= cnt_ff + 6'h01;
    if (cnt_ff >= 6'h01 && cnt_ff <= 6'h18)
      sh_ff <= {sh_ff[22:0], capture_serial_out_pin};
    if (cnt_ff == 6'h19 && slot_ff) left_word <= sh_ff;
    if (cnt_ff == 6'h19 && !slot_ff) right_word <= sh_ff;
  end
endmodule

// ===== verification/tb_top.sv
// top bench: spi host tasks, core step stimulus, link receiver model.
// assumes the ramp shortened to 16 clocks and a 160 ns bit clock.
module tb_top import dncap_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RAMP = 16;
  localparam int RW = $clog2(RAMP + 1);
  logic              clock, srst, spi_sclk, spi_cs_n, spi_mosi;
  logic              core_step_valid, spi_miso, spi_miso_oe_n, core_run;
  logic              bclk, lrclk, capture_serial_out_pin;
  logic [8:0]        core_pc, stp;
  logic [RW-1:0]     volume_level;
  logic [SRC_W-1:0]  data_src_sel, mclk_src_sel;
  logic [23:0]       left_word, right_word;
  logic [31:0]       rd;
  logic [7:0]        d8;
  logic [ADDR_W-1:0] a;
  dncap_taps_s       core_taps, t, t2;
  int                mismatches, samples_checked;

  dncap_top #(.RAMP_CYCLES_P(RAMP)) dncap_top_inst (.clock(clock),
    .srst(srst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe_n(spi_miso_oe_n), .core_step_valid(core_step_valid),
    .core_pc(core_pc), .core_taps(core_taps), .core_run(core_run),
    .volume_level(volume_level), .data_src_sel(data_src_sel),
    .mclk_src_sel(mclk_src_sel), .bclk(bclk), .lrclk(lrclk),
    .capture_serial_out_pin(capture_serial_out_pin));
  dncap_link_rx dncap_link_rx_inst (.bclk(bclk), .lrclk(lrclk),
    .capture_serial_out_pin(capture_serial_out_pin),
    .left_word(left_word), .right_word(right_word));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // expected capture: select code picks the tap, mult out clipped
  function automatic logic [23:0] exp_cap(input logic [1:0] s,
                                          input dncap_taps_s x);
    case (s)
      2'h0: exp_cap = (&x.mult_out[27:23] || ~|x.mult_out[27:23]) ?
              x.mult_out[23:0] : (x.mult_out[27] ? 24'h80_0000 : 24'h7f_ffff);
      2'h1: exp_cap = x.log_level_output;
      2'h2: exp_cap = x.multiplier_data_in;
      default: exp_cap = x.multiplier_coef_in;
    endcase
  endfunction
  function automatic dncap_taps_s rnd_taps();
    logic [127:0] r;
    r = {$urandom(), $urandom(), $urandom(), $urandom()};
    return r[99:0];
  endfunction
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // half sclk period, 520 ns keeps under 1 MHz
  task automatic hw();
    repeat (13) @(posedge clock);
    #1;
  endtask
  task automatic spi_bit(input logic b, output logic r);
    spi_mosi = b;
    hw();
    spi_sclk = 1'b1;
    r = spi_miso;
    hw();
    spi_sclk = 1'b0;
  endtask
  task automatic spi_wr(input logic [9:0] ad, input logic [15:0] d);
    logic [31:0] w;
    logic        r;
    w = {5'h00, 1'b0, ad, d};
    spi_cs_n = 1'b0;
    hw();
    for (int i = 31; i >= 0; i--) spi_bit(w[i], r);
    hw();
    spi_cs_n = 1'b1;
    hw();
    hw();
  endtask
  task automatic spi_rd(input logic [9:0] ad, output logic [31:0] d);
    logic [15:0] h;
    logic        r;
    h = {5'h00, 1'b1, ad};
    spi_cs_n = 1'b0;
    hw();
    for (int i = 15; i >= 0; i--) spi_bit(h[i], r);
    for (int i = 31; i >= 0; i--) spi_bit(1'b0, d[i]);
    hw();
    spi_cs_n = 1'b1;
    hw();
    hw();
  endtask
  task automatic step(input logic [8:0] pc, input dncap_taps_s x);
    core_pc = pc;
    core_taps = x;
    core_step_valid = 1'b1;
    @(posedge clock);
    #1;
    core_step_valid = 1'b0;
    @(posedge clock);
    #1;
  endtask
  // bounded wait on the core run flag
  task automatic wait_run(input logic v);
    for (int n = 0; n < 200 && core_run !== v; n++) @(posedge clock);
    #1;
    chk(32'(core_run), 32'(v), "core run");
    if (core_run !== v) end_of_test();
  endtask
  initial begin
    repeat (90000) @(posedge clock);
    mismatches++;
    $display("[ERR] %0t run limit reached", $time);
    end_of_test();
  end

  initial begin
    {srst, spi_sclk, spi_cs_n, spi_mosi} = 4'h5;
    {core_step_valid, core_pc, core_taps} = '0;
    mismatches = 0;
    samples_checked = 0;
    void'($urandom(58));
    repeat (24) @(posedge clock);
    #1;
    srst = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk(32'(volume_level), 32'(RAMP), "volume at reset");
    // both host units, every select code, step 0 and 511 corners
    for (int k = 0; k < 6; k++) begin
      stp = (k == 0) ? 9'h000 : (k == 5) ? 9'h1ff : 9'($urandom());
      t = rnd_taps();
      if (k == 4) t.mult_out = {{5{t.mult_out[23]}}, t.mult_out[22:0]};
      a = k[0] ? ADDR_HOST_CAP2 : ADDR_HOST_CAP1;
      spi_wr(a, {5'h00, stp, k[1:0]});
      step(stp, t);
      step(stp ^ 9'h001, ~t);
      spi_rd(a, rd);
      chk(rd, {8'h00, exp_cap(k[1:0], t)}, "host capture");
    end
    spi_rd(ADDR_SER_CAP1, rd);
    chk(rd, 32'h0000_0000, "write-only read");
    spi_rd(10'h0ff, rd);
    chk(rd, 32'h0000_0000, "unmapped read");
    spi_wr(ADDR_CTRL1, 16'h0080);
    wait_run(1'b0);
    chk(32'(volume_level), 32'h0000_0000, "volume halted");
    spi_rd(ADDR_CTRL1, rd);
    chk(rd, 32'h0200_0000, "shutdown status");
    d8 = 8'($urandom());
    spi_wr(ADDR_CTRL2, {8'h00, d8});
    chk({data_src_sel, mclk_src_sel}, {d8[5:4], d8[7:6]}, "sources");
    spi_wr(ADDR_CTRL1, 16'h0000);
    wait_run(1'b1);
    repeat (RAMP + 4) @(posedge clock);
    #1;
    chk(32'(volume_level), 32'(RAMP), "volume restored");
    // serial units: left then right slot, msb first
    spi_wr(ADDR_SER_CAP1, {5'h00, 9'h0a3, SEL_MULT_DATA});
    spi_wr(ADDR_SER_CAP2, {5'h00, 9'h1ff, SEL_MULT_COEF});
    t = rnd_taps();
    t2 = rnd_taps();
    step(9'h0a3, t);
    step(9'h1ff, t2);
    repeat (800) @(posedge clock);
    #1;
    chk({8'h00, left_word}, {8'h00, t.multiplier_data_in}, "left");
    chk({8'h00, right_word}, {8'h00, t2.multiplier_coef_in}, "right");
    end_of_test();
  end
endmodule
